// File: hdl/edc_pkg.sv
package edc_pkg;

   // clock and conversion
   localparam int CLK_PERIOD_NS = 10;

   // least times round up, never below one cycle
   function automatic int edc_cycles_up(input int time_ns);
      int cyc;
      cyc = (time_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (cyc < 1) ? 1 : cyc;
   endfunction

   // longest times round down, never below one cycle
   function automatic int edc_cycles_down(input int time_ns);
      int cyc;
      cyc = time_ns / CLK_PERIOD_NS;
      return (cyc < 1) ? 1 : cyc;
   endfunction

   // memory geometry
   localparam int ROW_BITS = 10;
   localparam int COL_BITS = 10;
   localparam int ADDR_BITS = ROW_BITS + COL_BITS;
   localparam int DATA_BITS = 16;
   localparam int REFRESH_ROWS = 1024;
   localparam int WAKE_CYCLES = 8;

   // device timing, slower grade, in ns
   localparam int T_RP_NS = 40;
   localparam int T_RAS_MIN_NS = 60;
   localparam int T_RCD_NS = 14;
   localparam int T_AA_NS = 30;
   localparam int T_CP_NS = 9;
   localparam int T_PC_NS = 25;
   localparam int T_CSR_NS = 5;
   localparam int T_CHR_NS = 10;
   localparam int T_RASP_MAX_NS = 100000;
   localparam int T_POWERUP_NS = 200000;
   localparam int T_REF_NS = 16000000;

   // derived cycle counts
   localparam int RP_CYC = edc_cycles_up(T_RP_NS);
   localparam int RAS_MIN_CYC = edc_cycles_up(T_RAS_MIN_NS);
   localparam int RCD_CYC = edc_cycles_up(T_RCD_NS);
   localparam int CP_CYC = edc_cycles_up(T_CP_NS);
   localparam int PC_CYC = edc_cycles_up(T_PC_NS);
   localparam int CAS_ACCESS_CYC = edc_cycles_up(T_AA_NS);
   localparam int CAS_LOW_CYC = (CAS_ACCESS_CYC + CP_CYC >= PC_CYC) ?
                                CAS_ACCESS_CYC : PC_CYC - CP_CYC;
   localparam int CSR_CYC = edc_cycles_up(T_CSR_NS);
   localparam int CHR_CYC = edc_cycles_up(T_CHR_NS);
   localparam int CBR_LOW_CYC = (RAS_MIN_CYC > CHR_CYC) ? RAS_MIN_CYC : CHR_CYC;
   localparam int PAGE_OPEN_MAX_CYC = edc_cycles_down(T_RASP_MAX_NS);
   localparam int PAGE_GUARD_CYC = 16;
   localparam int POWERUP_CYC = edc_cycles_up(T_POWERUP_NS);
   localparam int REF_INTERVAL_CYC = edc_cycles_down(T_REF_NS / REFRESH_ROWS);

   // counter widths
   localparam int TIMER_BITS = 16;
   localparam int DEBT_BITS = 12;

   // controller states
   typedef enum logic [3:0] {
      ST_POWERUP = 4'h0,
      ST_IDLE = 4'h1,
      ST_ACT = 4'h2,
      ST_COL = 4'h3,
      ST_CASHI = 4'h4,
      ST_CLOSE = 4'h5,
      ST_PRECH = 4'h6,
      ST_CBR_CAS = 4'h7,
      ST_CBR_RAS = 4'h8,
      ST_SELF = 4'h9
   } edc_state_t;

endpackage

// File: hdl/edc_wait_timer.sv
`timescale 1ns/1ps

// down counter; expired once a load has run out
module edc_wait_timer
   import edc_pkg::*;
#(
   parameter int WIDTH = TIMER_BITS,
   parameter logic [TIMER_BITS-1:0] RESET_COUNT = 16'h0000
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic load,
   input wire logic [WIDTH-1:0] load_value,
   output logic expired
);

   logic [WIDTH-1:0] count;

   // a pending load masks the old zero
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         count <= WIDTH'(RESET_COUNT);
      end
      else if (load)
      begin
         count <= load_value;
      end
      else if (count != '0)
      begin
         count <= count - 1'b1;
      end
   end

   assign expired = (count == '0) && !load;

endmodule

// File: hdl/edc_refresh_timer.sv
`timescale 1ns/1ps

// paces refreshes and counts those owed
module edc_refresh_timer
   import edc_pkg::*;
#(
   parameter int INTERVAL = REF_INTERVAL_CYC,
   parameter int DEBT_LIMIT = REFRESH_ROWS
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic refresh_done,
   input wire logic debt_clear,
   output logic refresh_due,
   output logic refresh_overdue
);

   logic [TIMER_BITS-1:0] tick_count;
   logic tick;
   logic [DEBT_BITS-1:0] debt;

   // one tick per row interval
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         tick_count <= '0;
         tick <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (!enable)
         begin
            tick_count <= '0;
         end
         else if (tick_count >= TIMER_BITS'(INTERVAL - 1))
         begin
            tick_count <= '0;
            tick <= 1'b1;
         end
         else
         begin
            tick_count <= tick_count + 1'b1;
         end
      end
   end

   // owed refreshes; a tick and a completion in one cycle cancel
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         debt <= '0;
      end
      else if (debt_clear)
      begin
         debt <= '0;
      end
      else if (tick && !refresh_done && debt != '1)
      begin
         debt <= debt + 1'b1;
      end
      else if (!tick && refresh_done && debt != '0)
      begin
         debt <= debt - 1'b1;
      end
   end

   assign refresh_due = (debt != '0);
   // a whole period owed: rows may be lost
   assign refresh_overdue = (debt >= DEBT_BITS'(DEBT_LIMIT));

endmodule

// File: hdl/edc_controller.sv
`timescale 1ns/1ps

// Behaviour
// - all 1,024 rows are refreshed within each 16 ms; here a request in idle, and one still pending after a precharge, goes before a due refresh.
// - self refresh spreads the 1,024 refreshes over up to 128 ms.
// - after power-up wait 200 us, then eight refreshes before any access.
// - the eight-refresh wake-up repeats once the refresh period is overrun.
// - both column strobes go high for the column precharge to start afresh.
// - page-mode column accesses are at least 25 ns apart.
// - the row strobe stays low at most 100,000 ns in page mode; here the limit is checked only in idle with no request waiting.
// - read-modify-write needs 133 ns and page read-write 68 ns.
// - in a refresh the column strobe leads the row strobe by 5 ns.
// - in a hidden refresh output enable settles by the row edge.
module edc_controller
   import edc_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC,
   parameter int PAGE_OPEN_MAX = PAGE_OPEN_MAX_CYC,
   parameter int REFRESH_INTERVAL = REF_INTERVAL_CYC,
   parameter int REFRESH_DEBT_LIMIT = REFRESH_ROWS
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_BITS-1:0] req_addr,
   input wire logic [DATA_BITS-1:0] req_wdata,
   input wire logic [1:0] req_byte_en,
   input wire logic self_refresh_req,
   input wire logic [DATA_BITS-1:0] dq_in,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_BITS-1:0] rsp_rdata,
   output logic self_refresh_active,
   output logic row_strobe_n,
   output logic upper_byte_column_strobe_n,
   output logic lower_byte_column_strobe_n,
   output logic write_enable_n,
   output logic output_enable_n,
   output logic [ROW_BITS-1:0] dram_addr,
   output logic [DATA_BITS-1:0] dq_out,
   output logic dq_oe
);

   localparam logic [TIMER_BITS-1:0] PAGE_LIMIT =
      TIMER_BITS'(PAGE_OPEN_MAX - PAGE_GUARD_CYC);

   edc_state_t state;
   logic [1:0] phase;
   logic [3:0] wake_left;
   logic row_open;
   logic [ROW_BITS-1:0] open_row;
   logic pend;
   logic cur_write;
   logic [ROW_BITS-1:0] cur_row;
   logic [COL_BITS-1:0] cur_col;
   logic [DATA_BITS-1:0] cur_wdata;
   logic [1:0] cur_be;
   logic [TIMER_BITS-1:0] ras_time;
   logic tmr_load;
   logic [TIMER_BITS-1:0] tmr_value;
   logic tmr_expired;
   logic refresh_done;
   logic debt_clear;
   logic timer_run;
   logic refresh_due;
   logic refresh_overdue;
   logic need_refresh;

   assign need_refresh = refresh_due || (wake_left != 4'h0);

   // power-up pause is the timer's reset count
   edc_wait_timer #(
      .WIDTH(TIMER_BITS),
      .RESET_COUNT(TIMER_BITS'(POWERUP_WAIT))
   ) u_wait (
      .clk,
      .reset,
      .load(tmr_load),
      .load_value(tmr_value),
      .expired(tmr_expired)
   );

   edc_refresh_timer #(
      .INTERVAL(REFRESH_INTERVAL),
      .DEBT_LIMIT(REFRESH_DEBT_LIMIT)
   ) u_refresh (
      .clk,
      .reset,
      .enable(timer_run),
      .refresh_done,
      .debt_clear,
      .refresh_due,
      .refresh_overdue
   );

   // time the row strobe has been low, saturating
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ras_time <= '0;
      end
      else if (row_strobe_n)
      begin
         ras_time <= '0;
      end
      else if (ras_time != '1)
      begin
         ras_time <= ras_time + 1'b1;
      end
   end

   // refresh pacing waits for power-up
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         timer_run <= 1'b0;
      end
      else if (state != ST_POWERUP)
      begin
         timer_run <= 1'b1;
      end
   end

   // request capture, held until the column cycle ends
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cur_write <= 1'b0;
         cur_row <= '0;
         cur_col <= '0;
         cur_wdata <= '0;
         cur_be <= 2'h0;
      end
      else if (state == ST_IDLE && req_valid && req_ready)
      begin
         cur_write <= req_write;
         cur_row <= req_addr[ADDR_BITS-1:COL_BITS];
         cur_col <= req_addr[COL_BITS-1:0];
         cur_wdata <= req_wdata;
         // no lane named means both lanes
         cur_be <= (req_byte_en == 2'h0) ? 2'h3 : req_byte_en;
      end
   end

   // sequencer and pin drive
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state <= ST_POWERUP;
         phase <= 2'h0;
         wake_left <= 4'h0;
         row_open <= 1'b0;
         open_row <= '0;
         pend <= 1'b0;
         req_ready <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         self_refresh_active <= 1'b0;
         row_strobe_n <= 1'b1;
         upper_byte_column_strobe_n <= 1'b1;
         lower_byte_column_strobe_n <= 1'b1;
         write_enable_n <= 1'b1;
         output_enable_n <= 1'b1;
         dram_addr <= '0;
         dq_out <= '0;
         dq_oe <= 1'b0;
         tmr_load <= 1'b0;
         tmr_value <= '0;
         refresh_done <= 1'b0;
         debt_clear <= 1'b0;
      end
      else
      begin
         rsp_valid <= 1'b0;
         tmr_load <= 1'b0;
         refresh_done <= 1'b0;
         debt_clear <= 1'b0;
         // a period owed: rows may have decayed
         if (refresh_overdue && wake_left == 4'h0)
         begin
            wake_left <= 4'(WAKE_CYCLES);
            debt_clear <= 1'b1;
         end
         case (state)
            ST_POWERUP:
            begin
               if (tmr_expired)
               begin
                  wake_left <= 4'(WAKE_CYCLES);
                  state <= ST_CBR_CAS;
               end
            end
            ST_IDLE:
            begin
               if (req_valid && req_ready)
               begin
                  req_ready <= 1'b0;
                  pend <= 1'b1;
                  if (row_open && open_row == req_addr[ADDR_BITS-1:COL_BITS])
                  begin
                     state <= ST_COL;
                  end
                  else if (row_open)
                  begin
                     state <= ST_CLOSE;
                  end
                  else
                  begin
                     dram_addr <= req_addr[ADDR_BITS-1:COL_BITS];
                     state <= ST_ACT;
                  end
               end
               else if (need_refresh || self_refresh_req ||
                        (row_open && ras_time >= PAGE_LIMIT))
               begin
                  req_ready <= 1'b0;
                  state <= row_open ? ST_CLOSE : ST_CBR_CAS;
               end
            end
            ST_ACT:
            begin
               if (!row_open)
               begin
                  row_strobe_n <= 1'b0;
                  row_open <= 1'b1;
                  open_row <= cur_row;
                  tmr_value <= TIMER_BITS'(RCD_CYC);
                  tmr_load <= 1'b1;
               end
               else if (tmr_expired)
               begin
                  state <= ST_COL;
               end
            end
            ST_COL:
            begin
               case (phase)
                  2'h0:
                  begin
                     // early write: enable leads the strobe,
                     // so no read-write cycle forms
                     dram_addr <= cur_col;
                     write_enable_n <= !cur_write;
                     output_enable_n <= cur_write;
                     dq_out <= cur_wdata;
                     dq_oe <= cur_write;
                     phase <= 2'h1;
                  end
                  2'h1:
                  begin
                     upper_byte_column_strobe_n <= !cur_be[1];
                     lower_byte_column_strobe_n <= !cur_be[0];
                     tmr_value <= TIMER_BITS'(CAS_LOW_CYC);
                     tmr_load <= 1'b1;
                     phase <= 2'h2;
                  end
                  default:
                  begin
                     if (tmr_expired)
                     begin
                        // data is still held while the strobe is low
                        if (!cur_write)
                        begin
                           rsp_rdata <= dq_in;
                        end
                        rsp_valid <= 1'b1;
                        pend <= 1'b0;
                        upper_byte_column_strobe_n <= 1'b1;
                        lower_byte_column_strobe_n <= 1'b1;
                        write_enable_n <= 1'b1;
                        output_enable_n <= 1'b1;
                        dq_oe <= 1'b0;
                        // strobe low plus precharge spans the page cycle
                        tmr_value <= TIMER_BITS'(CP_CYC);
                        tmr_load <= 1'b1;
                        phase <= 2'h0;
                        state <= ST_CASHI;
                     end
                  end
               endcase
            end
            ST_CASHI:
            begin
               if (tmr_expired)
               begin
                  req_ready <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            ST_CLOSE:
            begin
               // the row may not rise before its least low time
               if (ras_time >= TIMER_BITS'(RAS_MIN_CYC))
               begin
                  row_strobe_n <= 1'b1;
                  row_open <= 1'b0;
                  tmr_value <= TIMER_BITS'(RP_CYC);
                  tmr_load <= 1'b1;
                  state <= ST_PRECH;
               end
            end
            ST_PRECH:
            begin
               // row precharge outlasts column precharge,
               // so the next cycle starts clean
               if (tmr_expired)
               begin
                  if (pend)
                  begin
                     dram_addr <= cur_row;
                     state <= ST_ACT;
                  end
                  else if (need_refresh || self_refresh_req)
                  begin
                     state <= ST_CBR_CAS;
                  end
                  else
                  begin
                     req_ready <= 1'b1;
                     state <= ST_IDLE;
                  end
               end
            end
            ST_CBR_CAS:
            begin
               if (phase == 2'h0)
               begin
                  // output enable parked high before any row edge
                  output_enable_n <= 1'b1;
                  write_enable_n <= 1'b1;
                  upper_byte_column_strobe_n <= 1'b0;
                  lower_byte_column_strobe_n <= 1'b0;
                  tmr_value <= TIMER_BITS'(CSR_CYC);
                  tmr_load <= 1'b1;
                  phase <= 2'h1;
               end
               else if (tmr_expired)
               begin
                  // column strobes lead; the device picks the row itself
                  row_strobe_n <= 1'b0;
                  tmr_value <= TIMER_BITS'(CBR_LOW_CYC);
                  tmr_load <= 1'b1;
                  phase <= 2'h0;
                  state <= ST_CBR_RAS;
               end
            end
            ST_CBR_RAS:
            begin
               if (tmr_expired)
               begin
                  if (self_refresh_req && wake_left == 4'h0)
                  begin
                     // held low, the device refreshes on its own
                     self_refresh_active <= 1'b1;
                     state <= ST_SELF;
                  end
                  else
                  begin
                     row_strobe_n <= 1'b1;
                     upper_byte_column_strobe_n <= 1'b1;
                     lower_byte_column_strobe_n <= 1'b1;
                     refresh_done <= 1'b1;
                     if (wake_left != 4'h0)
                     begin
                        wake_left <= wake_left - 4'h1;
                     end
                     tmr_value <= TIMER_BITS'(RP_CYC);
                     tmr_load <= 1'b1;
                     state <= ST_PRECH;
                  end
               end
            end
            ST_SELF:
            begin
               if (!self_refresh_req)
               begin
                  row_strobe_n <= 1'b1;
                  upper_byte_column_strobe_n <= 1'b1;
                  lower_byte_column_strobe_n <= 1'b1;
                  self_refresh_active <= 1'b0;
                  // the dwell is unknown to us, so wake up afresh
                  wake_left <= 4'(WAKE_CYCLES);
                  debt_clear <= 1'b1;
                  tmr_value <= TIMER_BITS'(RP_CYC);
                  tmr_load <= 1'b1;
                  state <= ST_PRECH;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

endmodule

// File: verif/edc_controller_asserts.sv
`timescale 1ns/1ps

// watches the strobe pins and the ready flag of the controller
module edc_checker
   import edc_pkg::*;
#(
   parameter int POWERUP_WAIT = POWERUP_CYC,
   parameter int PAGE_OPEN_MAX = PAGE_OPEN_MAX_CYC,
   parameter int REFRESH_INTERVAL = REF_INTERVAL_CYC
)
(
   input wire logic clk,
   input wire logic reset,
   input wire logic req_ready,
   input wire logic self_refresh_active,
   input wire logic row_strobe_n,
   input wire logic upper_byte_column_strobe_n,
   input wire logic lower_byte_column_strobe_n,
   input wire logic write_enable_n,
   input wire logic output_enable_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   int up_cnt;
   int cbr_cnt;
   int ras_cnt;
   int gap_cnt;
   logic ras_q;
   logic act_q;
   logic run;
   logic cas_lo;
   logic cbr_fall;
   assign cas_lo = !upper_byte_column_strobe_n && !lower_byte_column_strobe_n;
   assign cbr_fall = ras_q && !row_strobe_n && cas_lo;
   // history and counters; self refresh excluded
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         ras_q <= 1'b1;
         act_q <= 1'b0;
         run <= 1'b0;
         up_cnt <= 0;
         cbr_cnt <= 0;
         ras_cnt <= 0;
         gap_cnt <= 0;
      end
      else
      begin
         ras_q <= row_strobe_n;
         act_q <= self_refresh_active;
         run <= run || req_ready;
         up_cnt <= (up_cnt < POWERUP_WAIT) ? up_cnt + 1 : up_cnt;
         cbr_cnt <= (self_refresh_active && !act_q) ? 0 : cbr_cnt + (cbr_fall ? 1 : 0);
         ras_cnt <= (row_strobe_n || self_refresh_active) ? 0 : ras_cnt + 1;
         gap_cnt <= (!run || cbr_fall || self_refresh_active) ? 0 : gap_cnt + 1;
      end
   end
   sequence s_cbr;
      $fell(row_strobe_n) && cas_lo;
   endsequence
   property p_cbr_lead;
      s_cbr |-> $past(cas_lo);
   endproperty
   a_cbr_lead: assert property (p_cbr_lead) else $error("no column lead");
   property p_cbr_quiet;
      s_cbr |-> output_enable_n && write_enable_n;
   endproperty
   a_cbr_quiet: assert property (p_cbr_quiet) else $error("enables active in a refresh");
   property p_oe_in_row;
      !output_enable_n |-> !row_strobe_n && !self_refresh_active;
   endproperty
   a_oe_in_row: assert property (p_oe_in_row) else $error("stray output enable");
   property p_page_gap(logic s);
      $fell(s) |=> (!$fell(s)) [*2];
   endproperty
   a_page_gap_u: assert property (p_page_gap(upper_byte_column_strobe_n))
      else $error("upper strobes too close");
   a_page_gap_l: assert property (p_page_gap(lower_byte_column_strobe_n))
      else $error("lower strobes too close");
   property p_open_max;
      ras_cnt <= PAGE_OPEN_MAX;
   endproperty
   a_open_max: assert property (p_open_max) else $error("row held open too long");
   property p_precharge;
      $rose(row_strobe_n) |-> row_strobe_n [*4];
   endproperty
   a_precharge: assert property (p_precharge) else $error("row precharge cut short");
   property p_powerup;
      $fell(row_strobe_n) |-> up_cnt >= POWERUP_WAIT;
   endproperty
   a_powerup: assert property (p_powerup) else $error("row strobe too early");
   property p_ready_wake;
      req_ready |-> cbr_cnt >= WAKE_CYCLES;
   endproperty
   a_ready_wake: assert property (p_ready_wake) else $error("ready before wake-up");
   property p_refresh_gap;
      gap_cnt <= REFRESH_INTERVAL + 64;
   endproperty
   a_refresh_gap: assert property (p_refresh_gap) else $error("refresh gap too long");
endmodule

bind edc_controller edc_checker #(.POWERUP_WAIT(POWERUP_WAIT), .PAGE_OPEN_MAX(PAGE_OPEN_MAX),
   .REFRESH_INTERVAL(REFRESH_INTERVAL)) chk_u (.clk, .reset, .req_ready, .self_refresh_active,
   .row_strobe_n, .upper_byte_column_strobe_n, .lower_byte_column_strobe_n, .write_enable_n,
   .output_enable_n);

// File: verif/edc_dram_model.sv
`timescale 1ns/1ps

// behavioural memory behind the strobes; has no clock of its own
module edc_dram_model
   import edc_pkg::*;
(
   input wire logic row_strobe_n,
   input wire logic upper_byte_column_strobe_n,
   input wire logic lower_byte_column_strobe_n,
   input wire logic write_enable_n,
   input wire logic output_enable_n,
   input wire logic [ROW_BITS-1:0] dram_addr,
   input wire logic [DATA_BITS-1:0] dq_bus,
   output logic [DATA_BITS-1:0] dq_q,
   output logic [1:0] dq_drv
);
   logic [DATA_BITS-1:0] mem [logic [ADDR_BITS-1:0]];
   logic [ROW_BITS-1:0] row = 10'h000;
   logic [ROW_BITS-1:0] ref_row = 10'h000;
   logic [DATA_BITS-1:0] last = 16'h0000;
   logic [ADDR_BITS-1:0] key;
   logic row_open = 1'b0;
   int cbr_count = 0;
   // column low at row fall: refresh, output kept
   always @(negedge row_strobe_n)
   begin
      if (!upper_byte_column_strobe_n || !lower_byte_column_strobe_n)
      begin
         ref_row = ref_row + 10'h001;
         cbr_count = cbr_count + 1;
      end
      else
      begin
         row = dram_addr;
         row_open = 1'b1;
      end
   end
   always @(posedge row_strobe_n) row_open = 1'b0;
   // no decay modelled
   always @(negedge upper_byte_column_strobe_n or negedge lower_byte_column_strobe_n)
   begin
      if (row_open)
      begin
         key = {row, dram_addr};
         if (!mem.exists(key)) mem[key] = 16'h0000;
         if (!write_enable_n && !upper_byte_column_strobe_n) mem[key][15:8] = dq_bus[15:8];
         if (!write_enable_n && !lower_byte_column_strobe_n) mem[key][7:0] = dq_bus[7:0];
         if (write_enable_n) last = mem[key];
      end
   end
   // a lane drives only while its strobe is low; else the inverse
   assign dq_drv[1] = !upper_byte_column_strobe_n && !output_enable_n && write_enable_n;
   assign dq_drv[0] = !lower_byte_column_strobe_n && !output_enable_n && write_enable_n;
   assign dq_q = {dq_drv[1] ? last[15:8] : ~last[15:8], dq_drv[0] ? last[7:0] : ~last[7:0]};
endmodule

// File: verif/edc_controller_tb.sv
`timescale 1ns/1ps

module edc_controller_tb
   import edc_pkg::*;
;
   localparam int PW = 50;
   localparam int PO = 64;
   localparam int RI = 200;
   logic clk, reset, req_valid, req_write, self_refresh_req, req_ready, rsp_valid, sra;
   logic [ADDR_BITS-1:0] req_addr;
   logic [DATA_BITS-1:0] req_wdata, rsp_rdata, dq_out, dq_q, dq_bus, q;
   logic [1:0] req_byte_en, dq_drv;
   logic ras_n, upper_byte_column_strobe_n_n, lower_byte_column_strobe_n_n, we_n, oe_n, dq_oe;
   logic [ROW_BITS-1:0] dram_addr;
   int failures = 0;
   int total_checks = 0;
   int cycles = 0;
   int c0;
   assign dq_bus = dq_oe ? dq_out : dq_q;
   edc_controller #(.POWERUP_WAIT(PW), .PAGE_OPEN_MAX(PO), .REFRESH_INTERVAL(RI),
      .REFRESH_DEBT_LIMIT(4)) dut_u (.clk, .reset, .req_valid, .req_write, .req_addr,
      .req_wdata, .req_byte_en, .self_refresh_req, .dq_in(dq_bus), .req_ready, .rsp_valid,
      .rsp_rdata, .self_refresh_active(sra), .row_strobe_n(ras_n),
      .upper_byte_column_strobe_n(upper_byte_column_strobe_n_n), .lower_byte_column_strobe_n(lower_byte_column_strobe_n_n),
      .write_enable_n(we_n), .output_enable_n(oe_n), .dram_addr, .dq_out, .dq_oe);
   edc_dram_model mdl_u (.row_strobe_n(ras_n), .upper_byte_column_strobe_n(upper_byte_column_strobe_n_n),
      .lower_byte_column_strobe_n(lower_byte_column_strobe_n_n), .write_enable_n(we_n), .output_enable_n(oe_n),
      .dram_addr, .dq_bus, .dq_q, .dq_drv);
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_min(input string what, input int lo, input int got);
      total_checks++;
      if (got < lo)
      begin
         failures++;
         $display("BAD %s expected at least %0d seen %0d", what, lo, got);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // waits at falling edges for a flag, bounded
   task automatic wait_flag(ref logic f, input int lim, output int n);
      n = 0;
      while (f !== 1'b1 && n < lim)
      begin
         @(negedge clk);
         n++;
      end
   endtask
   // request held until taken, then the answer
   task automatic access(input logic wr, input logic [19:0] a, input logic [15:0] d,
                         input logic [1:0] be);
      int n;
      req_write = wr;
      req_addr = a;
      req_wdata = d;
      req_byte_en = be;
      req_valid = 1'b1;
      wait_flag(req_ready, 400, n);
      @(negedge clk);
      req_valid = 1'b0;
      wait_flag(rsp_valid, 60, n);
      check_word("rsp_valid", 16'h0001, {15'h0000, rsp_valid});
      q = rsp_rdata;
      @(negedge clk);
   endtask
   task automatic t_wakeup();
      int n;
      wait_flag(req_ready, 1000, n);
      check_min("power-up cycles", PW, n);
      check_min("wake-up refreshes", WAKE_CYCLES, mdl_u.cbr_count);
   endtask
   // page hits, lanes and row changes
   task automatic t_data();
      access(1'b1, 20'h01403, 16'hA55A, 2'b11);
      access(1'b1, 20'h01403, 16'h3C00, 2'b10);
      access(1'b0, 20'h01403, 16'h0000, 2'b11);
      check_word("upper lane write", 16'h3C5A, q);
      access(1'b1, 20'h02401, 16'h1234, 2'b00);
      access(1'b0, 20'h02401, 16'h0000, 2'b11);
      check_word("other row", 16'h1234, q);
      access(1'b0, 20'h01403, 16'h0000, 2'b11);
      check_word("row back", 16'h3C5A, q);
   endtask
   task automatic t_page_close();
      access(1'b0, 20'h01C00, 16'h0000, 2'b11);
      repeat (PO + 8) @(negedge clk);
      check_word("row closed", 16'h0001, {15'h0000, ras_n});
   endtask
   task automatic t_refresh();
      c0 = mdl_u.cbr_count;
      repeat (3 * RI + 60) @(negedge clk);
      check_min("idle refreshes", 3, mdl_u.cbr_count - c0);
      check_min("refresh spread", 0, 4 - (mdl_u.cbr_count - c0));
   endtask
   task automatic t_self();
      int n;
      self_refresh_req = 1'b1;
      wait_flag(sra, 200, n);
      c0 = mdl_u.cbr_count;
      repeat (300) @(negedge clk);
      check_word("held strobes", 16'h0000, {14'h0000, ras_n, upper_byte_column_strobe_n_n});
      self_refresh_req = 1'b0;
      wait_flag(req_ready, 1000, n);
      check_min("wake after self", WAKE_CYCLES, mdl_u.cbr_count - c0);
      access(1'b0, 20'h01403, 16'h0000, 2'b11);
      check_word("kept data", 16'h3C5A, q);
   endtask
   initial
   begin
      reset = 1'b1;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 20'h00000;
      req_wdata = 16'h0000;
      req_byte_en = 2'b11;
      self_refresh_req = 1'b0;
      repeat (6) @(negedge clk);
      reset = 1'b0;
      t_wakeup();
      t_data();
      t_page_close();
      t_refresh();
      t_self();
      close_out();
   end
   // hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles >= 8000)
      begin
         failures++;
         close_out();
      end
   end
endmodule
